// *** verilog/contact_pkg.sv ***
/*
  shared constants and carriers for the output contact configuration logic:
  register offsets, reset values, switch field layout, pulse and delay times.
  assumes a 40 MHz reference clock; all times are in milliseconds.
*/
package contact_pkg;

  // clock rate and derived cycles per millisecond
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // register addresses on the plain register port
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  OFF_SWITCHES  = 4'h0;
  localparam logic [3:0]  OFF_CHECKSUM  = 4'h1;
  localparam logic [3:0]  OFF_EXPECT    = 4'h2;
  localparam logic [3:0]  OFF_OUTPUTS   = 4'h3;
  localparam logic [3:0]  OFF_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_CLR   = 4'h5;
  localparam logic [3:0]  OFF_IRQ_EN    = 4'h6;
  localparam logic [3:0]  OFF_UNLATCH   = 4'h7;

  // values after reset
  localparam logic [7:0]  SWITCHES_RST  = 8'h00;
  localparam logic [7:0]  EXPECT_RST    = 8'h00;
  localparam logic [7:0]  IRQ_EN_RST    = 8'h00;

  // interrupt status bit positions
  localparam int unsigned IRQ_HEAVY0    = 0;
  localparam int unsigned IRQ_CBF       = 3;
  localparam int unsigned IRQ_TCS       = 4;
  localparam int unsigned IRQ_UNLATCH   = 5;
  localparam int unsigned IRQ_CSUM      = 6;

  // minimum pulse lengths and breaker failure operate time, in ms
  localparam int unsigned SIG_LONG_MS   = 80;
  localparam int unsigned SIG_SHORT_MS  = 40;
  localparam int unsigned HEAVY_LONG_MS = 80;
  localparam int unsigned HEAVY_SHORT_MS = 40;
  localparam int unsigned CBF_TIME_MS   = 100;

  // counter width; covers the longest operate time at 40 MHz
  localparam int unsigned CNT_W         = 32;

  // pin synchroniser reset level
  localparam logic        SYNC_RST      = 1'b0;

  // switch word, switch 8 in the msb, switch 1 in the lsb
  typedef struct packed {
    logic       tcs_to_sig_two;
    logic       restart_not_routed;
    logic       cbf_enable;
    logic       heavy_short_pulse;
    logic       sig_short_pulse;
    logic [2:0] heavy_latch;
  } switches_type;

  // live output contact image as read back by software
  typedef struct packed {
    logic [1:0] signal_out;
    logic [2:0] heavy_latched;
    logic [2:0] heavy_out;
  } contact_state_type;

endpackage : contact_pkg

// *** verilog/pin_sync.sv ***
/*
  three stage synchroniser for pin inputs with agreement filter.
  assumes the input is asynchronous to ref_clk; a change is accepted once
  the second and third stages agree.
*/
`timescale 1ns/10ps
module pin_sync
  import contact_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // pin and filtered level
  input  wire logic pin_async,
  output logic      level
);

  logic stage1_reg, stage2_reg, stage3_reg, level_reg;
  logic stage1_next, stage2_next, stage3_next, level_next;

  // shift chain; only stage two reads stage one
  always_comb begin
    stage1_next = pin_async;
    stage2_next = stage1_reg;
    stage3_next = stage2_reg;
    level_next  = (stage2_reg == stage3_reg) ? stage3_reg : level_reg;
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1_reg <= SYNC_RST;
      stage2_reg <= SYNC_RST;
      stage3_reg <= SYNC_RST;
      level_reg  <= SYNC_RST;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
      stage3_reg <= stage3_next;
      level_reg  <= level_next;
    end
  end

  assign level = level_reg;

endmodule : pin_sync

// *** verilog/min_pulse.sv ***
/*
  minimum pulse stretcher: a rising request loads the length, and the
  stretch stays active until the count runs out.
  assumes request and length come from logic on ref_clk.
*/
`timescale 1ns/10ps
module min_pulse
  import contact_pkg::*;
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // request and selected length in cycles
  input  wire logic             request,
  input  wire logic [CNT_W-1:0] length,
  // stretched level
  output logic                  active
);

  logic             req_reg, req_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;

  // reload on rising request, else count down to zero
  always_comb begin
    req_next = request;
    if (request && !req_reg) begin
      cnt_next = length;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      req_reg <= req_next;
      cnt_reg <= cnt_next;
    end
  end

  assign active = request || (cnt_reg != '0);

endmodule : min_pulse

// *** verilog/output_contact_config.sv ***
/*
  output contact configuration: latching, minimum pulses, breaker failure
  re-trip, restart inhibit and supervision warning routing, all steered by
  the switch word, plus a small register port and one interrupt line.
  assumes trip requests come from protection logic on ref_clk, and the
  digital unlatch input and the supervision warning come from pins.
  limits: an unlatch clears the latch only, so a running minimum pulse
  still finishes; an unlatch never clears a contact whose trip is live.
  the contact image leaves out breaker-failure operate, which shows in
  interrupt status instead. the breaker-failure time is a parameter.
  routing group five lives outside this block.

*/
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
module output_contact_config
  import contact_pkg::*;
#(
  parameter int unsigned SIG_LONG_CYC    = SIG_LONG_MS * CYC_PER_MS,
  parameter int unsigned SIG_SHORT_CYC   = SIG_SHORT_MS * CYC_PER_MS,
  parameter int unsigned HEAVY_LONG_CYC  = HEAVY_LONG_MS * CYC_PER_MS,
  parameter int unsigned HEAVY_SHORT_CYC = HEAVY_SHORT_MS * CYC_PER_MS,
  parameter int unsigned CBF_TIME_CYC    = CBF_TIME_MS * CYC_PER_MS
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  // protection requests, same clock
  input  wire logic [2:0]        heavy_trip_req,
  input  wire logic [1:0]        signal_req,
  input  wire logic              restart_inhibit,
  input  wire logic              panel_unlatch,
  input  wire logic              bus_unlatch,
  // pins from outside the clock domain
  input  wire logic              unlatch_pin,
  input  wire logic              tcs_warning_pin,
  // contacts and interrupt
  output logic                   heavy_output_one,
  output logic                   heavy_output_two,
  output logic                   heavy_output_three,
  output logic                   signal_output_one,
  output logic                   signal_output_two,
  output logic                   csum_mismatch,
  output logic                   irq
);

  switches_type      sw_reg, sw_next;
  logic [7:0]        expect_reg, expect_next;
  logic [7:0]        irq_stat_reg, irq_stat_next;
  logic [7:0]        irq_en_reg, irq_en_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic              irq_reg, irq_next;
  logic              mism_reg, mism_next;
  logic [2:0]        latch_reg, latch_next;
  logic [CNT_W-1:0]  cbf_cnt_reg, cbf_cnt_next;
  logic              cbf_fire_reg, cbf_fire_next;
  logic [2:0]        heavy_reg, heavy_next;
  logic [1:0]        sig_reg, sig_next;
  logic              tcs_prev_reg, tcs_prev_next;
  contact_state_type state_now;
  logic [7:0]        checksum;
  logic              unlatch_sync, tcs_sync, unlatch_any;
  logic              bus_sel_wr_unlatch;
  logic [2:0]        heavy_src, heavy_stretch;
  logic [1:0]        sig_src, sig_stretch;
  logic [CNT_W-1:0]  heavy_len, sig_len;

  // pin synchronisers
  pin_sync u_unlatch_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (unlatch_pin),
    .level     (unlatch_sync)
  );

  pin_sync u_tcs_sync (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .pin_async (tcs_warning_pin),
    .level     (tcs_sync)
  );

  // weighted checksum, switch n weighs two to the n minus one
  always_comb begin
    checksum = 8'h00;
    for (int n = 0; n < 8; n++) begin
      if (sw_reg[n]) begin
        checksum = checksum + 8'(1 << n);
      end
    end
  end

  // unlatch from any of the four sources
  assign bus_sel_wr_unlatch = reg_write && (reg_addr == OFF_UNLATCH);
  assign unlatch_any = panel_unlatch || unlatch_sync || bus_unlatch
                       || bus_sel_wr_unlatch;

  // pulse lengths chosen by the switch word
  assign sig_len   = sw_reg.sig_short_pulse ? CNT_W'(SIG_SHORT_CYC)
                                             : CNT_W'(SIG_LONG_CYC);
  assign heavy_len = sw_reg.heavy_short_pulse ? CNT_W'(HEAVY_SHORT_CYC)
                                               : CNT_W'(HEAVY_LONG_CYC);

  // sources feeding each contact
  always_comb begin
    heavy_src[0] = heavy_trip_req[0];
    heavy_src[1] = heavy_trip_req[1] || cbf_fire_reg;
    heavy_src[2] = heavy_trip_req[2]
                   || (restart_inhibit && !sw_reg.restart_not_routed);
    sig_src[0]   = signal_req[0];
    sig_src[1]   = signal_req[1]
                   || (tcs_sync && sw_reg.tcs_to_sig_two);
  end

  // minimum pulse per contact
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_heavy
      min_pulse u_heavy_pulse (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .request (heavy_src[gi]),
        .length  (heavy_len),
        .active  (heavy_stretch[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_sig
      min_pulse u_sig_pulse (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .request (sig_src[gi]),
        .length  (sig_len),
        .active  (sig_stretch[gi])
      );
    end
  endgenerate

  // latching of heavy trips; a live trip wins over an unlatch
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (heavy_src[i] && sw_reg.heavy_latch[i]) begin
        latch_next[i] = 1'b1;
      end else if (unlatch_any) begin
        latch_next[i] = 1'b0;
      end else if (!sw_reg.heavy_latch[i]) begin
        latch_next[i] = 1'b0;
      end else begin
        latch_next[i] = latch_reg[i];
      end
    end
  end

  // breaker failure timer runs while trip one persists
  always_comb begin
    cbf_cnt_next  = '0;
    cbf_fire_next = 1'b0;
    if (sw_reg.cbf_enable && heavy_trip_req[0]) begin
      if (cbf_cnt_reg >= CNT_W'(CBF_TIME_CYC - 1)) begin
        cbf_cnt_next  = cbf_cnt_reg;
        cbf_fire_next = 1'b1;
      end else begin
        cbf_cnt_next  = cbf_cnt_reg + 1'b1;
      end
    end
  end

  // contact drive: trip, stretch, or held latch
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      heavy_next[i] = heavy_stretch[i] || latch_next[i];
    end
    sig_next      = sig_stretch;
  end

  // previous warning level for the rise detector
  always_comb begin
    tcs_prev_next = tcs_sync;
  end

  // register port writes and read answer
  always_comb begin
    sw_next     = sw_reg;
    expect_next = expect_reg;
    irq_en_next = irq_en_reg;
    rdata_next  = 8'h00;
    if (reg_write) begin
      unique case (reg_addr)
        OFF_SWITCHES: sw_next     = switches_type'(reg_wdata);
        OFF_EXPECT:   expect_next = reg_wdata;
        OFF_IRQ_EN:   irq_en_next = reg_wdata;
        OFF_CHECKSUM, OFF_OUTPUTS, OFF_IRQ_STAT: ; // read only
        default:      ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        OFF_SWITCHES: rdata_next = sw_reg;
        OFF_CHECKSUM: rdata_next = checksum;
        OFF_EXPECT:   rdata_next = expect_reg;
        OFF_OUTPUTS:  rdata_next = state_now;
        OFF_IRQ_STAT: rdata_next = irq_stat_reg;
        OFF_IRQ_EN:   rdata_next = irq_en_reg;
        OFF_IRQ_CLR, OFF_UNLATCH: rdata_next = 8'h00; // write only
        default:      rdata_next = 8'h00;
      endcase
    end
  end

  // readable contact image
  always_comb begin
    state_now.signal_out    = sig_reg;
    state_now.heavy_latched = latch_reg;
    state_now.heavy_out     = heavy_reg;
  end

  // checksum compare against the expected value
  always_comb begin
    mism_next = (checksum != expect_reg);
  end

  // sticky events; a set in the same cycle beats a clear
  always_comb begin
    logic [7:0] ev;
    ev = 8'h00;
    for (int i = 0; i < 3; i++) begin
      ev[IRQ_HEAVY0 + i] = heavy_next[i] && !heavy_reg[i];
    end
    ev[IRQ_CBF]     = cbf_fire_next && !cbf_fire_reg;
    ev[IRQ_TCS]     = tcs_sync && !tcs_prev_reg;
    ev[IRQ_UNLATCH] = unlatch_any && (latch_reg != 3'b000);
    ev[IRQ_CSUM]    = mism_next && !mism_reg;
    irq_stat_next = irq_stat_reg;
    if (reg_write && (reg_addr == OFF_IRQ_CLR)) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata;
    end
    irq_stat_next = irq_stat_next | ev;
    irq_next      = |(irq_stat_next & irq_en_next);
  end

  // registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_reg       <= switches_type'(SWITCHES_RST);
      expect_reg   <= EXPECT_RST;
      irq_en_reg   <= IRQ_EN_RST;
      irq_stat_reg <= 8'h00;
      rdata_reg    <= 8'h00;
      irq_reg      <= 1'b0;
      mism_reg     <= 1'b0;
      latch_reg    <= 3'b000;
      cbf_cnt_reg  <= '0;
      cbf_fire_reg <= 1'b0;
      heavy_reg    <= 3'b000;
      sig_reg      <= 2'b00;
      tcs_prev_reg <= 1'b0;
    end else begin
      sw_reg       <= sw_next;
      expect_reg   <= expect_next;
      irq_en_reg   <= irq_en_next;
      irq_stat_reg <= irq_stat_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
      mism_reg     <= mism_next;
      latch_reg    <= latch_next;
      cbf_cnt_reg  <= cbf_cnt_next;
      cbf_fire_reg <= cbf_fire_next;
      heavy_reg    <= heavy_next;
      sig_reg      <= sig_next;
      tcs_prev_reg <= tcs_prev_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata          = rdata_reg;
  assign heavy_output_one   = heavy_reg[0];
  assign heavy_output_two   = heavy_reg[1];
  assign heavy_output_three = heavy_reg[2];
  assign signal_output_one  = sig_reg[0];
  assign signal_output_two  = sig_reg[1];
  assign csum_mismatch      = mism_reg;
  assign irq                = irq_reg;

endmodule : output_contact_config

// *** verification/contact_properties.sv ***
/*
  concurrent checks on the output contact block ports.
  assumes a bind into output_contact_config with its cycle parameters.
*/
`timescale 1ns/10ps
module contact_properties
  import contact_pkg::*;
#(
  parameter int unsigned HEAVY_LONG_CYC = 20,
  parameter int unsigned CBF_TIME_CYC   = 30
)
(
  // clock, reset and register writes
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_write,
  // requests and unlatch sources
  input wire logic [2:0]        heavy_trip_req,
  input wire logic [1:0]        signal_req,
  input wire logic              restart_inhibit,
  input wire logic              panel_unlatch,
  input wire logic              bus_unlatch,
  input wire logic              unlatch_pin,
  input wire logic              tcs_warning_pin,
  // contacts
  input wire logic              heavy_output_one,
  input wire logic              heavy_output_two,
  input wire logic              heavy_output_three,
  input wire logic              signal_output_one,
  input wire logic              signal_output_two,
  input wire logic              csum_mismatch
);
  logic [7:0]  sw_q;
  logic [7:0]  exp_q;
  logic        quiet;
  int unsigned idle_age;
  int unsigned lat_age;
  int unsigned cbf_age;
  int unsigned tcs_age;

  // no unlatch source of any kind this cycle
  assign quiet = !(panel_unlatch || bus_unlatch || unlatch_pin ||
                   (reg_write && reg_addr == OFF_UNLATCH));

  // register shadows and ages of watched conditions, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_q     <= SWITCHES_RST;
      exp_q    <= EXPECT_RST;
      idle_age <= 0;
      lat_age  <= 0;
      cbf_age  <= 0;
      tcs_age  <= 0;
    end else begin
      if (reg_write && reg_addr == OFF_SWITCHES) sw_q <= reg_wdata;
      if (reg_write && reg_addr == OFF_EXPECT) exp_q <= reg_wdata;
      idle_age <= heavy_trip_req[0] ? 0 : idle_age + (idle_age < 999);
      lat_age  <= (heavy_trip_req[0] && sw_q[0]) ? 1 :
                  (lat_age != 0 && quiet && sw_q[0]) ?
                  lat_age + (lat_age < 999) : 0;
      cbf_age  <= (heavy_trip_req[0] && sw_q[5]) ?
                  cbf_age + (cbf_age < 999) : 0;
      tcs_age  <= tcs_warning_pin ? tcs_age + (tcs_age < 999) : 0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence restart_rise;
    sw_q[6] && $rose(restart_inhibit) && !heavy_trip_req[2];
  endsequence

  sequence latched_long;
    lat_age > HEAVY_LONG_CYC + 3;
  endsequence

  trip_follow_a: assert property (
    heavy_trip_req[0] |=> heavy_output_one) else $error("trip not out");
  sig_follow_a: assert property (
    signal_req[0] |=> signal_output_one) else $error("signal not out");
  latch_hold_a: assert property (
    latched_long |-> heavy_output_one) else $error("latch lost");
  unlatch_clear_a: assert property (
    panel_unlatch && idle_age > HEAVY_LONG_CYC + 3 |-> ##[1:3]
    !heavy_output_one) else $error("unlatch ignored");
  cbf_fire_a: assert property (
    cbf_age > CBF_TIME_CYC + 4 |-> heavy_output_two)
    else $error("no delayed retrip");
  restart_route_a: assert property (
    !sw_q[6] && restart_inhibit |=> heavy_output_three)
    else $error("restart not routed");
  restart_block_a: assert property (
    restart_rise ##0 !heavy_output_three |=> !heavy_output_three)
    else $error("restart leaked");
  tcs_route_a: assert property (
    sw_q[7] && tcs_age > 6 |=> signal_output_two)
    else $error("warning not routed");
  csum_match_a: assert property (
    $stable(sw_q) && $stable(exp_q) |-> csum_mismatch == (sw_q != exp_q))
    else $error("checksum flag wrong");
endmodule : contact_properties

bind output_contact_config contact_properties #(
  .HEAVY_LONG_CYC(HEAVY_LONG_CYC),
  .CBF_TIME_CYC(CBF_TIME_CYC)
) contact_properties_i (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .heavy_trip_req,
  .signal_req, .restart_inhibit, .panel_unlatch, .bus_unlatch,
  .unlatch_pin, .tcs_warning_pin, .heavy_output_one, .heavy_output_two,
  .heavy_output_three, .signal_output_one, .signal_output_two,
  .csum_mismatch
);

// *** verification/trip_circuit_model.sv ***
/*
  breaker and trip circuit beside the output contacts.
  assumes contacts on ref_clk; warning and push button are asynchronous.
*/
`timescale 1ns/10ps
module trip_circuit_model
#(
  parameter int unsigned OPEN_CYC = 6
)
(
  // clock
  input wire logic ref_clk,
  // trip coils and scenario commands
  input wire logic heavy_output_one,
  input wire logic heavy_output_two,
  input wire logic stuck,
  input wire logic coil_open,
  input wire logic push,
  // supervision, push button and breaker state
  output logic     tcs_warning_pin,
  output logic     unlatch_pin,
  output logic     breaker_open
);
  int unsigned age;

  // a stuck main breaker only opens through the backup coil
  always @(posedge ref_clk) begin
    if (!(heavy_output_one && !stuck) && !heavy_output_two) age <= 0;
    else if (age < OPEN_CYC) age <= age + 1;
  end
  assign breaker_open = (age == OPEN_CYC);

  // pins change off the clock grid
  assign #7 tcs_warning_pin = coil_open;
  assign #11 unlatch_pin = push;
endmodule : trip_circuit_model

// *** verification/output_contact_config_tb_top.sv ***
/*
  self-checking bench for the output contact configuration block.
  assumes the checker bind and the trip circuit model are compiled too.
*/
`timescale 1ns/10ps
module output_contact_config_tb_top
  import contact_pkg::*;
  ;
  localparam int unsigned HL  = 20;
  localparam int unsigned HS  = 10;
  localparam int unsigned SL  = 16;
  localparam int unsigned SS  = 8;
  localparam int unsigned CBF = 30;
  logic              ref_clk, rst_n, reg_write, reg_read;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata;
  logic [2:0]        heavy_trip_req;
  logic [1:0]        signal_req;
  logic              restart_inhibit, panel_unlatch, bus_unlatch;
  logic              unlatch_pin, tcs_warning_pin, csum_mismatch, irq;
  logic              heavy_output_one, heavy_output_two, heavy_output_three;
  logic              signal_output_one, signal_output_two;
  logic              stuck, coil_open, push, breaker_open;
  logic [4:0]        outs;
  int                n_fail, num_checks;

  // contacts by request index
  assign outs = {signal_output_two, signal_output_one, heavy_output_three,
                 heavy_output_two, heavy_output_one};

  output_contact_config #(.SIG_LONG_CYC(SL), .SIG_SHORT_CYC(SS),
    .HEAVY_LONG_CYC(HL), .HEAVY_SHORT_CYC(HS), .CBF_TIME_CYC(CBF)
  ) output_contact_config_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .heavy_trip_req, .signal_req,
    .restart_inhibit, .panel_unlatch, .bus_unlatch, .unlatch_pin,
    .tcs_warning_pin, .heavy_output_one, .heavy_output_two,
    .heavy_output_three, .signal_output_one, .signal_output_two,
    .csum_mismatch, .irq);

  trip_circuit_model trip_circuit_model_i (.ref_clk, .heavy_output_one,
    .heavy_output_two, .stuck, .coil_open, .push, .tcs_warning_pin,
    .unlatch_pin, .breaker_open);

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : cmp

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(posedge ref_clk);
    cmp(nm, e, reg_rdata);
  endtask : rd

  task automatic fire(input int idx);
    @(posedge ref_clk);
    {signal_req, heavy_trip_req} <= 5'h01 << idx;
    @(posedge ref_clk);
    {signal_req, heavy_trip_req} <= 5'h00;
  endtask : fire

  task automatic pulse(input logic [7:0] sw, input int idx, input int len);
    int n;
    n = 0;
    wr(OFF_SWITCHES, sw);
    fire(idx);
    cyc(1);
    while (outs[idx] === 1'b1 && n < 200) begin
      n++;
      @(posedge ref_clk);
    end
    cmp("pulse length", 8'h01, {7'h00, n >= len - 1 && n <= len + 3});
  endtask : pulse

  task automatic t_regs();
    logic [7:0] v;
    logic [7:0] s;
    v = 8'ha5;
    s = 8'h00;
    for (int n = 1; n <= 8; n++) s += {7'h00, v[n-1]} << (n - 1);
    rd(OFF_SWITCHES, SWITCHES_RST, "switches reset");
    rd(OFF_EXPECT, EXPECT_RST, "expected reset");
    rd(OFF_IRQ_EN, IRQ_EN_RST, "enable reset");
    rd(4'h8, 8'h00, "unmapped");
    wr(OFF_SWITCHES, v);
    wr(OFF_CHECKSUM, 8'h00);
    rd(OFF_CHECKSUM, s, "checksum");
    cmp("checksum flag", 8'h01, csum_mismatch);
    wr(OFF_EXPECT, s);
    cyc(3);
    cmp("checksum match", 8'h00, csum_mismatch);
  endtask : t_regs

  task automatic t_pulse();
    pulse(8'h00, 0, HL);
    pulse(8'h10, 1, HS);
    pulse(8'h00, 3, SL);
    pulse(8'h08, 4, SS);
  endtask : t_pulse

  task automatic t_latch();
    wr(OFF_SWITCHES, 8'h01);
    cyc(4);
    wr(OFF_IRQ_CLR, 8'hff);
    fire(0);
    cyc(3);
    cmp("irq masked", 8'h00, irq);
    rd(OFF_IRQ_STAT, 8'h01, "status");
    wr(OFF_IRQ_EN, 8'h01);
    cyc(2);
    cmp("irq raised", 8'h01, irq);
    wr(OFF_IRQ_CLR, 8'h01);
    cyc(2);
    cmp("irq cleared", 8'h00, irq);
    for (int s = 0; s < 4; s++) begin
      fire(0);
      cyc(HL + 8);
      cmp("latched", 8'h01, heavy_output_one);
      case (s)
        0: panel_unlatch <= 1'b1;
        1: bus_unlatch <= 1'b1;
        2: push <= 1'b1;
        default: wr(OFF_UNLATCH, 8'h00);
      endcase
      cyc(6);
      {push, bus_unlatch, panel_unlatch} <= 3'b000;
      cyc(8);
      cmp("unlatched", 8'h00, heavy_output_one);
    end
    wr(OFF_SWITCHES, 8'h06);
    fire(1);
    fire(2);
    cyc(HL + 8);
    cmp("latch 2 3", 8'h03, {6'h00, outs[2:1]});
    rd(OFF_OUTPUTS, 8'h36, "contact image");
    wr(OFF_UNLATCH, 8'h00);
    cyc(3);
    cmp("unlatch 2 3", 8'h00, {6'h00, outs[2:1]});
  endtask : t_latch

  task automatic t_cbf();
    int n;
    n = 0;
    wr(OFF_SWITCHES, 8'h00);
    stuck <= 1'b1;
    heavy_trip_req <= 3'b001;
    cyc(CBF + 10);
    cmp("no retrip", 8'h00, heavy_output_two);
    heavy_trip_req <= 3'b000;
    cyc(HL + 4);
    wr(OFF_SWITCHES, 8'h20);
    heavy_trip_req <= 3'b001;
    cyc(CBF - 4);
    cmp("early retrip", 8'h00, heavy_output_two);
    while (breaker_open !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    cmp("retrip", 8'h01, breaker_open);
    heavy_trip_req <= 3'b000;
    stuck <= 1'b0;
    wr(OFF_SWITCHES, 8'h00);
    cyc(HL + 4);
  endtask : t_cbf

  task automatic t_route();
    restart_inhibit <= 1'b1;
    cyc(3);
    cmp("restart routed", 8'h01, heavy_output_three);
    restart_inhibit <= 1'b0;
    cyc(HL + 4);
    wr(OFF_SWITCHES, 8'h40);
    restart_inhibit <= 1'b1;
    cyc(4);
    cmp("restart blocked", 8'h00, heavy_output_three);
    restart_inhibit <= 1'b0;
    wr(OFF_SWITCHES, 8'h80); // routing group five stays clear
    coil_open <= 1'b1;
    cyc(10);
    cmp("warning routed", 8'h01, signal_output_two);
    wr(OFF_SWITCHES, 8'h00);
    cyc(SL + 4);
    cmp("warning dropped", 8'h00, signal_output_two);
    coil_open <= 1'b0;
  endtask : t_route

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // reset, then the scenarios in turn
  initial begin
    n_fail = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {heavy_trip_req, signal_req, restart_inhibit} = '0;
    {panel_unlatch, bus_unlatch, stuck, coil_open, push} = '0;
    cyc(2);
    rst_n <= 1'b1;
    t_regs();
    t_pulse();
    t_latch();
    t_cbf();
    t_route();
    complete_run();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #(25 * 20000);
    n_fail++;
    complete_run();
  end
endmodule : output_contact_config_tb_top
